// ---- rtl/dsra_pkg.sv ----
package dsra_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int FILT_TIME_NS = 20;
  // Least time, so round up to whole cycles
  localparam int FILT_CYC = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);

  // ----------------------------------------------------------------
  // Protocol constants
  // ----------------------------------------------------------------
  localparam logic [5:0] SLAVE_ID_HIGH = 6'h2e;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] SPI_CMD_LAST = 4'h7;
  localparam logic [3:0] SPI_BLOCK_FIRST = 4'h8;
  localparam logic [3:0] SPI_BLOCK_LAST = 4'hf;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] TX_IDLE = 8'hff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_SUB,
    I2C_WDATA,
    I2C_RDATA
  } dsra_i2c_state_type;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dsra_reg_req_type;

endpackage

// ---- rtl/dsra_serial_slave.sv ----
`timescale 1ns/1ps
module dsra_serial_slave
  import dsra_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic chip_select, // Mode select and serial frame pin
  input wire logic serial_port_clock, // Shared clock pin
  input wire logic bidir_serial_line_in, // Data pad level
  output logic bidir_serial_line_out, // Data pad drive value
  output logic bidir_serial_line_oe, // Data pad driven
  input wire logic address_select_pin, // Strap level on output pad
  output logic serial_out_line, // Four-wire read data
  output logic serial_out_line_oe, // Four-wire output driven
  input wire logic three_wire_select, // Control bit: single data pin
  input wire logic auto_increment, // Control bit: address stepping
  output dsra_reg_req_type reg_req, // Register access request
  input wire logic [7:0] reg_rdata // Read data, cycle after reg_req.rd
);

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  logic [2:0] raw;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] clean;
  logic [2:0] clean_d;
  logic [3:0] fcnt [3];
  logic strap_a;
  logic strap_b;

  assign raw = {chip_select, bidir_serial_line_in, serial_port_clock};

  // Two flops per pin, then a stable-count filter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
      clean_d <= 3'h7;
      strap_a <= 1'b0;
      strap_b <= 1'b0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
      clean_d <= clean;
      strap_a <= address_select_pin;
      strap_b <= strap_a;
    end
  end

  // A change must persist FILT_CYC cycles, so spikes never reach the edges
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_filt
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          fcnt[g] <= 4'h0;
          clean[g] <= 1'b1;
        end else if (sync_b[g] == clean[g]) begin
          fcnt[g] <= 4'h0;
        end else if (fcnt[g] == FILT_LAST) begin
          clean[g] <= sync_b[g];
          fcnt[g] <= 4'h0;
        end else begin
          fcnt[g] <= fcnt[g] + 4'h1;
        end
      end
    end
  endgenerate

  a_filter_hold: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(clean[0]) |-> $past(fcnt[0]) == FILT_LAST)
    else $error("clock line passed filter early");

  // ----------------------------------------------------------------
  // Edge and condition decode
  // ----------------------------------------------------------------
  wire cs_hi = clean[2];
  wire spi_act = ~clean[2];
  wire sda = clean[1];
  // Only edges matter, so a clock held low by anyone simply waits
  wire clk_rise = clean[0] & ~clean_d[0];
  wire clk_fall = ~clean[0] & clean_d[0];
  wire clk_high = clean[0] & clean_d[0];
  wire start = cs_hi & clk_high & ~clean[1] & clean_d[1];
  wire stop = cs_hi & clk_high & clean[1] & ~clean_d[1];

  // ----------------------------------------------------------------
  // Two-wire slave
  // ----------------------------------------------------------------
  dsra_i2c_state_type state;
  logic [3:0] bcnt;
  logic ack_ph;
  logic i2c_low;
  logic [7:0] i_sh;
  logic [7:0] tx;
  logic [7:0] next_tx;

  wire id_match = (i_sh[7:1] == {SLAVE_ID_HIGH, strap_b});
  wire i_busy = cs_hi & (state != I2C_IDLE) & ~start & ~stop;
  wire i_byte_end = i_busy & clk_fall & (bcnt == BYTE_BITS) & ~ack_ph;
  wire i_ack_rise = i_busy & clk_rise & ack_ph;
  wire i_ack_end = i_busy & clk_fall & ack_ph;
  wire i_to_read = (state == I2C_ADDR) & i_sh[0];
  // Bit 7 of the sub-address is ignored; stepping follows the control bit
  wire i_sub_set = i_byte_end & (state == I2C_SUB);
  wire i_wr = i_byte_end & (state == I2C_WDATA);
  wire i_rd_req = i_ack_rise & (i_to_read | ((state == I2C_RDATA) & ~sda));
  wire i_tx_load = i_ack_end & (i_to_read | (state == I2C_RDATA));
  wire i_tx_shift = i_busy & clk_fall & (state == I2C_RDATA) & ~ack_ph
    & (bcnt != BYTE_BITS) & (bcnt != 4'h0);

  // Byte engine: sample on rise, act on fall, ninth clock is the ack slot
  always_ff @(posedge clk_sys) begin
    if (rst || !cs_hi) begin
      state <= I2C_IDLE;
      bcnt <= 4'h0;
      ack_ph <= 1'b0;
      i2c_low <= 1'b0;
      i_sh <= 8'h00;
    end else if (start) begin
      state <= I2C_ADDR;
      bcnt <= 4'h0;
      ack_ph <= 1'b0;
      i2c_low <= 1'b0;
    end else if (stop) begin
      state <= I2C_IDLE;
      ack_ph <= 1'b0;
      i2c_low <= 1'b0;
    end else if (state != I2C_IDLE) begin
      if (clk_rise && !ack_ph && bcnt != BYTE_BITS) begin
        i_sh <= {i_sh[6:0], sda};
        bcnt <= bcnt + 4'h1;
      end else if (i_ack_rise) begin
        if (state == I2C_RDATA && sda) begin
          state <= I2C_IDLE;
          i2c_low <= 1'b0;
        end
      end else if (i_byte_end) begin
        ack_ph <= 1'b1;
        if (state == I2C_ADDR && !id_match) begin
          state <= I2C_IDLE;
          i2c_low <= 1'b0;
        end else begin
          i2c_low <= (state != I2C_RDATA);
        end
      end else if (i_ack_end) begin
        ack_ph <= 1'b0;
        bcnt <= 4'h0;
        if (i_to_read) begin
          state <= I2C_RDATA;
        end else if (state == I2C_ADDR || state == I2C_SUB) begin
          state <= (state == I2C_ADDR) ? I2C_SUB : I2C_WDATA;
        end
        i2c_low <= i_tx_load & ~next_tx[7];
      end else if (i_tx_shift) begin
        i2c_low <= ~next_tx[7];
      end
    end
  end

  a_i2c_off_spi: assert property (@(posedge clk_sys) disable iff (rst)
    !cs_hi |=> !i2c_low && state == I2C_IDLE)
    else $error("two-wire slave active in serial mode");

  a_addr_nak_release: assert property (@(posedge clk_sys) disable iff (rst)
    (i_byte_end && state == I2C_ADDR && !id_match) |=> !bidir_serial_line_oe ##1
    !bidir_serial_line_oe)
    else $error("data driven after address mismatch");

  a_ack_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (i_busy && ack_ph && clk_high && state inside {I2C_SUB, I2C_WDATA})
    |-> bidir_serial_line_oe && !bidir_serial_line_out)
    else $error("acknowledge not held low in high phase");

  a_tx_release: assert property (@(posedge clk_sys) disable iff (rst)
    (i_byte_end && state == I2C_RDATA) |=> !i2c_low)
    else $error("data not released for host acknowledge");

  a_nak_release: assert property (@(posedge clk_sys) disable iff (rst)
    (i_ack_rise && state == I2C_RDATA && sda) |=> state == I2C_IDLE && !i2c_low)
    else $error("no-acknowledge did not release the line");

  a_stop_idle: assert property (@(posedge clk_sys) disable iff (rst)
    stop |=> state == I2C_IDLE && !i2c_low)
    else $error("stop did not end the transfer");

  // ----------------------------------------------------------------
  // Clocked serial slave
  // ----------------------------------------------------------------
  logic [3:0] scnt;
  logic [7:0] s_sh;
  logic s_rd;
  logic s_drv;

  wire s_rise = spi_act & clk_rise;
  wire s_fall = spi_act & clk_fall;
  wire s_addr_set = s_rise & (scnt == SPI_CMD_LAST);
  wire s_rd_req = s_rise & (((scnt == SPI_CMD_LAST) & s_sh[6])
    | ((scnt == SPI_BLOCK_LAST) & s_rd));
  wire s_wr = s_rise & (scnt == SPI_BLOCK_LAST) & ~s_rd;
  wire s_tx_load = s_fall & s_rd & (scnt == SPI_BLOCK_FIRST);
  wire s_tx_shift = s_fall & s_rd & (scnt > SPI_BLOCK_FIRST);

  // Bit counter wraps 15 to 8, so each extra byte is one 8-clock block
  always_ff @(posedge clk_sys) begin
    if (rst || cs_hi) begin
      scnt <= 4'h0;
      s_sh <= 8'h00;
      s_rd <= 1'b0;
      s_drv <= 1'b0;
    end else begin
      if (s_rise) begin
        s_sh <= {s_sh[6:0], sda};
        scnt <= (scnt == SPI_BLOCK_LAST) ? SPI_BLOCK_FIRST : scnt + 4'h1;
        if (scnt == SPI_CMD_LAST) begin
          s_rd <= s_sh[6];
        end
      end
      if (s_tx_load) begin
        s_drv <= 1'b1;
      end
    end
  end

  a_spi_write: assert property (@(posedge clk_sys) disable iff (rst)
    (s_rise && scnt == SPI_BLOCK_LAST && !s_rd) |=> reg_req.wr
    && reg_req.wdata == $past(s_sh[6:0]) * 2 + 8'($past(sda)))
    else $error("serial write byte not issued after 16th clock");

  a_spi_drive: assert property (@(posedge clk_sys) disable iff (rst)
    (s_tx_load && !three_wire_select) |=> serial_out_line_oe || cs_hi)
    else $error("read data not driven from bit 8");

  // ----------------------------------------------------------------
  // Shared register access and read shifter
  // ----------------------------------------------------------------
  logic rd_cap;
  logic [7:0] rbuf;

  wire set_addr = i_sub_set | s_addr_set;
  wire [6:0] set_val = i_sub_set ? i_sh[6:0] : {s_sh[5:0], sda};
  wire do_wr = i_wr | s_wr;
  wire [7:0] wval = i_wr ? i_sh : {s_sh[6:0], sda};
  wire tx_load = i_tx_load | s_tx_load;
  wire tx_shift = i_tx_shift | s_tx_shift;

  assign next_tx = tx_load ? rbuf : (tx_shift ? {tx[6:0], 1'b1} : tx);

  // Address steps once after each finished access when auto_increment is set, so reads prefetch ahead
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_req <= '0;
      rd_cap <= 1'b0;
      rbuf <= TX_IDLE;
      tx <= TX_IDLE;
    end else begin
      reg_req.rd <= i_rd_req | s_rd_req;
      reg_req.wr <= do_wr;
      if (do_wr) begin
        reg_req.wdata <= wval;
      end
      rd_cap <= reg_req.rd;
      if (rd_cap) begin
        rbuf <= reg_rdata;
      end
      if (set_addr) begin
        reg_req.addr <= set_val;
      end else if ((reg_req.wr || rd_cap) && auto_increment) begin
        reg_req.addr <= reg_req.addr + 7'h01;
      end
      tx <= next_tx;
    end
  end

  a_sub_load: assert property (@(posedge clk_sys) disable iff (rst)
    i_sub_set |=> reg_req.addr == 7'($past(i_sh)))
    else $error("sub-address not loaded");

  a_auto_step: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_req.wr && !set_addr) |=> reg_req.addr
    == $past(reg_req.addr) + 7'($past(auto_increment)))
    else $error("address step wrong after access");

  // ----------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------
  // Open-drain low in two-wire mode, push-pull in three-wire serial mode
  assign bidir_serial_line_out = spi_act & tx[7];
  assign bidir_serial_line_oe = spi_act ? (s_drv & three_wire_select) : i2c_low;
  assign serial_out_line = tx[7];
  assign serial_out_line_oe = spi_act & s_drv & ~three_wire_select;

endmodule

// ---- bench/dsra_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host master for both link modes, pacing a 125 ns link period
// ----------------------------------------------------------------
module dsra_host_model (
  input wire logic clk_sys, // System clock, paces the link
  input wire logic line, // Resolved data pad level
  input wire logic miso, // Read data pin for the current mode
  output logic chip_select, // Mode select and frame pin
  output logic serial_port_clock, // Link clock
  output logic host_oe, // Host drives the data pad
  output logic host_out // Host data value
);
  // Idle: two-wire mode, clock resting high, pad released
  initial begin
    chip_select = 1'b1;
    serial_port_clock = 1'b1;
    host_oe = 1'b0;
    host_out = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One frame: direction, address, then nb bytes MSB first from wd[31:24]
  task automatic spi(input logic rw, input logic [6:0] a, input int nb,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic [39:0] bits;
    bits = {rw, a, wd};
    rd = '0;
    chip_select = 1'b0;
    w(12);
    for (int i = 0; i < 8 + 8 * nb; i++) begin
      serial_port_clock = 1'b0; // Change on fall, sample on rise
      host_oe = !(rw && i >= 8);
      host_out = host_oe & bits[39 - i];
      w(12);
      serial_port_clock = 1'b1;
      if (i >= 8) rd = {rd[30:0], miso};
      w(13);
    end
    w(6);
    host_oe = 1'b0; // Released pad goes to the pull-up level
    chip_select = 1'b1;
    w(20);
  endtask

  // Open drain: the host only ever pulls low
  task automatic sda(input logic v);
    host_oe = !v;
    host_out = 1'b0;
  endtask

  // High phase sampled at both ends so a wobbling acknowledge shows
  task automatic pulse(output logic s0, output logic s1);
    w(6);
    serial_port_clock = 1'b1;
    s0 = line;
    w(13);
    s1 = line;
    serial_port_clock = 1'b0;
    w(6);
  endtask

  task automatic start; // Data falls while clock high
    sda(1'b1);
    w(6);
    serial_port_clock = 1'b1;
    w(6);
    sda(1'b0);
    w(6);
    serial_port_clock = 1'b0;
    w(6);
  endtask

  task automatic stop; // Data rises while clock high
    sda(1'b0);
    w(6);
    serial_port_clock = 1'b1;
    w(6);
    sda(1'b1);
    w(12);
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    logic s0, s1;
    for (int i = 7; i >= 0; i--) begin
      sda(b[i]);
      pulse(s0, s1);
    end
    sda(1'b1); // Release for the slave acknowledge
    pulse(s0, s1);
    ack = s0 | s1;
  endtask

  task automatic get(input logic nak, output logic [7:0] b);
    logic s0, s1;
    sda(1'b1);
    for (int i = 7; i >= 0; i--) begin
      pulse(s0, s1);
      b[i] = s1;
    end
    sda(nak); // Continue with low, end burst released
    pulse(s0, s1);
    sda(1'b1);
  endtask
endmodule

// ---- bench/tb_dual_serial_register_access_slave.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench: serial table first, then serial bursts and two-wire cases by hand
// ----------------------------------------------------------------
module tb_dual_serial_register_access_slave;
  import dsra_pkg::*;
  typedef struct {logic rw; logic tw; logic [6:0] a; logic [7:0] d;
                  logic [7:0] e;} dsra_row_type;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic tws = 1'b0;
  logic ainc = 1'b1;
  logic asel = 1'b1;
  logic cs, sck, h_oe, h_out, d_out, d_oe, sol, sol_oe, line, ack;
  dsra_reg_req_type req;
  logic [7:0] rdata;
  logic [14:0] wq[$];
  logic [31:0] rd;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  // Rows: direction, three-wire, address, byte sent, byte expected (read: addr ^ a5)
  dsra_row_type rows[4] = '{'{1'b0, 1'b0, 7'h10, 8'h3c, 8'h3c},
                            '{1'b1, 1'b0, 7'h7f, 8'h00, 8'hda},
                            '{1'b0, 1'b1, 7'h00, 8'hff, 8'hff},
                            '{1'b1, 1'b1, 7'h2a, 8'h00, 8'h8f}};

  always #2.5 clk_sys = ~clk_sys;
  // Wired-AND pad with pull-up
  assign line = (~d_oe | d_out) & (~h_oe | h_out);

  // Stand-in register file holds addr ^ a5, valid only in the cycle after a read strobe
  always @(posedge clk_sys) begin
    if (req.rd === 1'b1) rdata <= {1'b0, req.addr} ^ 8'ha5;
    else rdata <= 8'hxx;
  end

  dsra_serial_slave dut_u (
    .clk_sys(clk_sys),
    .rst(rst),
    .chip_select(cs),
    .serial_port_clock(sck),
    .bidir_serial_line_in(line),
    .bidir_serial_line_out(d_out),
    .bidir_serial_line_oe(d_oe),
    .address_select_pin(asel),
    .serial_out_line(sol),
    .serial_out_line_oe(sol_oe),
    .three_wire_select(tws),
    .auto_increment(ainc),
    .reg_req(req),
    .reg_rdata(rdata)
  );
  dsra_host_model host (
    .clk_sys(clk_sys),
    .line(line),
    .miso(tws ? line : (sol_oe ? sol : ~sol)), // Undriven output reads inverted
    .chip_select(cs),
    .serial_port_clock(sck),
    .host_oe(h_oe),
    .host_out(h_out)
  );

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wchk(input logic [6:0] a, input logic [7:0] d);
    if (wq.size() == 0) chk("write count", 1, 0);
    else chk("write", 32'({a, d}), 32'(wq.pop_front()));
  endtask

  task automatic say(input logic [7:0] b, input logic e);
    host.put(b, ack);
    chk("acknowledge", 32'(e), 32'(ack));
  endtask

  // Log write strobes; a hang ends the run as a mismatch
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (req.wr === 1'b1) wq.push_back({req.addr, req.wdata});
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk("reset outputs", 32'h80, 32'({d_oe, sol_oe, req.wr | req.rd, sol, req.addr}));
    host.w(10);
    foreach (rows[i]) begin
      tws = rows[i].tw;
      host.spi(rows[i].rw, rows[i].a, 1, {rows[i].d, 24'h0}, rd);
      if (rows[i].rw) chk("read byte", 32'(rows[i].e), 32'(rd[7:0]));
      else wchk(rows[i].a, rows[i].e);
    end
    // Bursts: fixed address, then stepping across the top address
    ainc = 1'b0;
    tws = 1'b0;
    host.spi(1'b0, 7'h11, 2, 32'h5a6b_0000, rd);
    wchk(7'h11, 8'h5a);
    wchk(7'h11, 8'h6b);
    ainc = 1'b1;
    host.spi(1'b1, 7'h7e, 3, 32'h0, rd);
    chk("burst read", 32'({8'h7e ^ 8'ha5, 8'h7f ^ 8'ha5, 8'ha5}), 32'(rd[23:0]));
    // Two-wire write burst; sub bit 7 carries no address
    host.start();
    say(8'hba, 1'b0);
    say(8'h85, 1'b0);
    say(8'h12, 1'b0);
    say(8'h34, 1'b0);
    host.stop();
    wchk(7'h05, 8'h12);
    wchk(7'h06, 8'h34);
    // Two-wire read burst with repeated start, last byte refused
    host.start();
    say(8'hba, 1'b0);
    say(8'ha0, 1'b0);
    host.start();
    say(8'hbb, 1'b0);
    host.get(1'b0, rd[15:8]);
    host.get(1'b1, rd[7:0]);
    host.w(12);
    chk("pad drive after refusal", 0, 32'(d_oe));
    host.stop();
    chk("two-wire read", 32'({8'h20 ^ 8'ha5, 8'h21 ^ 8'ha5}), 32'(rd[15:0]));
    // Foreign id: no acknowledge and no register access
    host.start();
    say(8'hb8, 1'b1);
    host.stop();
    chk("stray writes", 0, wq.size());
    // Mid-run reset, then the strap low selects the other id
    rst = 1'b1;
    asel = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk("reset again", 32'h80, 32'({d_oe, sol_oe, req.wr | req.rd, sol, req.addr}));
    host.w(10);
    host.start();
    say(8'hb8, 1'b0);
    say(8'h03, 1'b0);
    say(8'h77, 1'b0);
    host.stop();
    wchk(7'h03, 8'h77);
    tally_and_finish();
  end
endmodule
